// ===== pkg/scb_pkg.sv
// scb_pkg: register map, field positions, presets and enumerations
// for the servo configuration command bank.
// assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
`default_nettype none

package scb_pkg;

    // bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int CMD_W = 16;
    localparam int COEF_W = 8;
    localparam int COEF_N = 48;
    localparam int COEF_AW = 6;

    // register indices, byte address four times the index; coefficient bounds given as byte addresses
    localparam logic [7:0] IDX_GAIN_CAL = 8'h3C;
    localparam logic [7:0] IDX_STATUS = 8'h3D;
    localparam logic [7:0] IDX_CLK_CFG = 8'h3E;
    localparam logic [7:0] IDX_AUX_CFG = 8'h3F;
    localparam logic [ADDR_W-1:0] COEF_BASE = 10'h200;
    localparam logic [ADDR_W-1:0] COEF_LAST = 10'h2BC;

    // servo_aux_config field positions
    localparam int B_CAL_AMP_EN = 14;
    localparam int B_CLK_QUARTER = 13;
    localparam int B_CLK_HALF = 12;
    localparam int B_CLR_C = 10;
    localparam int B_CLR_B = 9;
    localparam int B_CLR_A = 8;
    localparam int B_SHOCK_GAIN = 6;
    localparam int B_SLOPE_QTR = 5;
    localparam int B_SHARED_BUF = 4;
    localparam int B_RO_UPPER = 3;
    localparam int B_RO_LOWER = 2;
    localparam int B_FREQ_HALF = 1;
    localparam logic [CMD_W-1:0] AUX_CFG_MASK = 16'h777E;
    localparam logic [CMD_W-1:0] AUX_CFG_RESET = 16'h0000;

    // other own fields
    localparam int B_CLK_UNDIV = 0;
    localparam int B_AMP_HI = 1;
    localparam int B_AMP_LO = 0;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // master clock division result
    typedef enum logic [1:0] {SCB_DIV_1, SCB_DIV_2, SCB_DIV_4} scb_div_t;

    // calibration sine amplitude selection
    typedef enum logic [2:0] {
        SCB_AMP_DEFAULT, SCB_AMP_1_64, SCB_AMP_1_32, SCB_AMP_1_16, SCB_AMP_1_8
    } scb_amp_t;

    // coefficient preset, K00 to K2F
    localparam logic [COEF_W-1:0] COEF_PRESET [0:COEF_N-1] = '{
        8'hE0, 8'h81, 8'h23, 8'h7F, 8'h6A, 8'h10, 8'h14, 8'h30,
        8'h7F, 8'h46, 8'h81, 8'h1C, 8'h7F, 8'h58, 8'h82, 8'h7F,
        8'h4E, 8'h32, 8'h20, 8'h30, 8'h80, 8'h77, 8'h80, 8'h77,
        8'h00, 8'hF1, 8'h7F, 8'h3B, 8'h81, 8'h44, 8'h7F, 8'h5E,
        8'h82, 8'h44, 8'h18, 8'h30, 8'h7F, 8'h46, 8'h81, 8'h3A,
        8'h7F, 8'h66, 8'h82, 8'h44, 8'h4E, 8'h1B, 8'h00, 8'h00
    };

endpackage : scb_pkg

`default_nettype wire

// ===== rtl/scb_config_bank.sv
// scb_config_bank: servo configuration command bank with axi4-lite slave,
// clock-division select, data ram clear, readout routing, coefficient preset.
// assumes lock, vibration and readout signals come from logic on clk_sys;
// the division select pin is asynchronous.
//
// How it works
// [RQ1] undivided bit forces divide-by-one over pin and both forced bits
// [RQ2] half bit gives 1/2, else quarter bit 1/4, else follow pin
// [RQ3] amplitude enable picks one of four codes, else default amplitude
// [RQ4] third clear bit zeroes words M08 to M0A while set
// [RQ5] second clear zeroes M00-M02 always; first only while lock is low
// [RQ6] software holds the two lower clear bits at least fifty microseconds
// [RQ7] shock-gain bit plus vibration forces focus filter to normal gain
// [RQ8] shared-buffer bit serves four input buffers with one amplifier
// [RQ9] software checks conversions through readout before shared-buffer mode; the host model only routes readout, when its first command sets it
// [RQ10] upper route uses pins 13,12,14; lower uses 10,9,11; default none
// [RQ11] software also enables the dac bit of the readout selection command; the host model sets no dac bit
// [RQ12] sine-halving bit halves the calibration sine frequency
// [RQ13] search-slope bit makes focus search ramp at quarter slope
// [RQ14] sled coefficients K00 to K05 preset as listed
// [RQ15] focus coefficients K06, K08 to K11 preset as listed
// [RQ16] tracking coefficients K19 to K22 preset as listed
// [RQ17] focus gain-down coefficients K24 to K2A, K2C, K2D preset as listed
// [RQ18] auto-gain, anti-shock and zero-cross coefficients preset as listed
// [RQ19] software leaves K18 at its preset zero
// [RQ20] unused K2E and K2F preset to zero
// [RQ21] command write replaces all sixteen bits; reserved bits read as zero
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none

module scb_config_bank #(
    parameter logic PIN_HIGH_HALVES = 1'b1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // axi4-lite
    input wire logic [scb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [scb_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [scb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [scb_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // surrounding servo logic
    input wire logic crystal_divide_pin,
    input wire logic lock_in,
    input wire logic vibration_detect,
    input wire logic readout_clock,
    input wire logic readout_latch_n,
    input wire logic readout_data,
    input wire logic [scb_pkg::COEF_AW-1:0] coef_rd_addr,
    output logic [scb_pkg::COEF_W-1:0] coef_rd_data,
    output scb_pkg::scb_div_t servo_master_div,
    output scb_pkg::scb_amp_t cal_amp_sel,
    output logic cal_freq_half,
    output logic search_slope_quarter,
    output logic shared_buffer_mode,
    output logic focus_force_normal,
    output logic clear_m00_m02,
    output logic clear_m08_m0a,
    output logic aux_out_pin_9,
    output logic aux_out_pin_9_oe,
    output logic aux_out_pin_10,
    output logic aux_out_pin_10_oe,
    output logic aux_out_pin_11,
    output logic aux_out_pin_11_oe,
    output logic aux_out_pin_12,
    output logic aux_out_pin_12_oe,
    output logic aux_out_pin_13,
    output logic aux_out_pin_13_oe,
    output logic aux_out_pin_14,
    output logic aux_out_pin_14_oe
);
    import scb_pkg::*;

    // checks run on clk_sys and rest in reset
    default clocking sys_cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // register decode, used by both write and read paths
    function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
        if (a[1:0] != 2'b00) begin
            decode = 3'd0;
        end else if (a[ADDR_W-1:2] == IDX_AUX_CFG) begin
            decode = 3'd1;
        end else if (a[ADDR_W-1:2] == IDX_CLK_CFG) begin
            decode = 3'd2;
        end else if (a[ADDR_W-1:2] == IDX_GAIN_CAL) begin
            decode = 3'd3;
        end else if (a[ADDR_W-1:2] == IDX_STATUS) begin
            decode = 3'd4;
        end else if (a >= COEF_BASE && a <= COEF_LAST) begin
            decode = 3'd5;
        end else begin
            decode = 3'd0;
        end
    endfunction : decode

    logic aw_held, w_held, clk_undiv, pin_level;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic [CMD_W-1:0] aux_cfg;
    logic [1:0] amp_code;
    logic [2:0] pin_sync;
    logic [COEF_W-1:0] coef [0:COEF_N-1];
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid, next_clk_undiv, next_pin_level;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [DATA_W-1:0] next_w_data, next_rdata;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp, next_amp_code;
    logic [CMD_W-1:0] next_aux_cfg;
    logic coef_we;
    logic [COEF_AW-1:0] coef_widx, rd_idx;
    logic [COEF_W-1:0] coef_wdata;
    scb_div_t next_div;
    scb_amp_t next_amp;
    logic [12:0] next_ctl, ctl;
    logic [11:0] next_pins, pins;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = s_axi_araddr[COEF_AW+1:2];

    // bus slave: address and data taken in either order, one write at a time
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_aux_cfg = aux_cfg;
        next_clk_undiv = clk_undiv;
        next_amp_code = amp_code;
        coef_we = 1'b0;
        coef_widx = aw_addr[COEF_AW+1:2];
        coef_wdata = w_data[COEF_W-1:0];
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            case (decode(aw_addr))
                3'd1: next_aux_cfg = w_data[CMD_W-1:0] & AUX_CFG_MASK; // RQ21
                3'd2: next_clk_undiv = w_data[B_CLK_UNDIV];
                3'd3: next_amp_code = w_data[1:0];
                3'd4: next_bresp = RESP_OKAY; // status ignores writes
                3'd5: coef_we = w_strb[0];
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        // read: the command register is write-only and reads zero
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            case (decode(s_axi_araddr))
                3'd1: next_rdata = '0;
                3'd2: next_rdata = {{(DATA_W-1){1'b0}}, clk_undiv};
                3'd3: next_rdata = {{(DATA_W-2){1'b0}}, amp_code};
                3'd4: next_rdata = {{(DATA_W-13){1'b0}}, ctl};
                3'd5: next_rdata = {{(DATA_W-COEF_W){1'b0}}, coef[rd_idx]};
                default: next_rresp = RESP_SLVERR;
            endcase
        end
    end

    // pin filter: level changes once second and third stages agree
    always_comb begin
        next_pin_level = pin_level;
        if (pin_sync[2] == pin_sync[1]) begin
            next_pin_level = pin_sync[1];
        end
    end

    // servo controls derived from the command bits
    always_comb begin
        if (clk_undiv) begin
            next_div = SCB_DIV_1; // RQ1
        end else if (aux_cfg[B_CLK_HALF]) begin
            next_div = SCB_DIV_2; // RQ2
        end else if (aux_cfg[B_CLK_QUARTER]) begin
            next_div = SCB_DIV_4; // RQ2
        end else if (pin_level == PIN_HIGH_HALVES) begin
            next_div = SCB_DIV_2; // RQ2
        end else begin
            next_div = SCB_DIV_1;
        end
        if (!aux_cfg[B_CAL_AMP_EN]) begin
            next_amp = SCB_AMP_DEFAULT; // RQ3
        end else begin
            case ({amp_code[B_AMP_HI], amp_code[B_AMP_LO]})
                2'b00: next_amp = SCB_AMP_1_64; // RQ3
                2'b01: next_amp = SCB_AMP_1_32;
                2'b10: next_amp = SCB_AMP_1_16;
                2'b11: next_amp = SCB_AMP_1_8;
                default: next_amp = SCB_AMP_DEFAULT;
            endcase
        end
        next_ctl = '0;
        next_ctl[1:0] = next_div;
        next_ctl[4:2] = next_amp;
        next_ctl[5] = aux_cfg[B_FREQ_HALF]; // RQ12
        next_ctl[6] = aux_cfg[B_SLOPE_QTR]; // RQ13
        next_ctl[7] = aux_cfg[B_SHARED_BUF]; // RQ8
        next_ctl[8] = aux_cfg[B_SHOCK_GAIN] && vibration_detect; // RQ7
        next_ctl[9] = aux_cfg[B_CLR_B] || (aux_cfg[B_CLR_A] && !lock_in); // RQ5
        next_ctl[10] = aux_cfg[B_CLR_C]; // RQ4
        next_ctl[11] = lock_in;
        next_ctl[12] = pin_level;
        // readout routes: clock, latch, data per pin set
        next_pins = '0;
        if (aux_cfg[B_RO_UPPER]) begin
            next_pins[6 +: 3] = {readout_data, readout_latch_n, readout_clock}; // RQ10
            next_pins[9 +: 3] = 3'b111;
        end
        if (aux_cfg[B_RO_LOWER]) begin
            next_pins[0 +: 3] = {readout_data, readout_latch_n, readout_clock}; // RQ10
            next_pins[3 +: 3] = 3'b111;
        end
    end

    // single register stage for all state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            aux_cfg <= AUX_CFG_RESET;
            clk_undiv <= 1'b0;
            amp_code <= '0;
            pin_sync <= '0;
            pin_level <= 1'b0;
            ctl <= '0;
            pins <= '0;
            coef_rd_data <= '0;
            coef <= COEF_PRESET; // RQ14 RQ15 RQ16 RQ17 RQ18 RQ20
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            aux_cfg <= next_aux_cfg;
            clk_undiv <= next_clk_undiv;
            amp_code <= next_amp_code;
            pin_sync <= {pin_sync[1:0], crystal_divide_pin};
            pin_level <= next_pin_level;
            ctl <= next_ctl;
            pins <= next_pins;
            coef_rd_data <= (coef_rd_addr < COEF_AW'(COEF_N)) ? coef[coef_rd_addr] : '0;
            if (coef_we) begin
                coef[coef_widx] <= coef_wdata;
            end
        end
    end

    assign servo_master_div = scb_div_t'(ctl[1:0]);
    assign cal_amp_sel = scb_amp_t'(ctl[4:2]);
    assign cal_freq_half = ctl[5];
    assign search_slope_quarter = ctl[6];
    assign shared_buffer_mode = ctl[7];
    assign focus_force_normal = ctl[8];
    assign clear_m00_m02 = ctl[9];
    assign clear_m08_m0a = ctl[10];
    assign {aux_out_pin_11, aux_out_pin_9, aux_out_pin_10} = pins[2:0];
    assign {aux_out_pin_11_oe, aux_out_pin_9_oe, aux_out_pin_10_oe} = pins[5:3];
    assign {aux_out_pin_14, aux_out_pin_12, aux_out_pin_13} = pins[8:6];
    assign {aux_out_pin_14_oe, aux_out_pin_12_oe, aux_out_pin_13_oe} = pins[11:9];

    // checks
    chk_undiv_wins: assert property ( // RQ1
        $past(clk_undiv) |-> servo_master_div == SCB_DIV_1)
        else $error("undivided select did not give divide by one");
    chk_half_quarter: assert property ( // RQ2
        !$past(clk_undiv) && $past(aux_cfg[B_CLK_QUARTER]) |->
        servo_master_div == ($past(aux_cfg[B_CLK_HALF]) ? SCB_DIV_2 : SCB_DIV_4))
        else $error("forced division ratio wrong");
    chk_amp_default: assert property ( // RQ3
        !$past(aux_cfg[B_CAL_AMP_EN]) |-> cal_amp_sel == SCB_AMP_DEFAULT)
        else $error("amplitude not default while disabled");
    chk_amp_code: assert property ( // RQ3
        $past(aux_cfg[B_CAL_AMP_EN]) && $past(amp_code) == 2'b11 |->
        cal_amp_sel == SCB_AMP_1_8)
        else $error("largest amplitude code not applied");
    chk_clear_hi: assert property ( // RQ4
        clear_m08_m0a == $past(aux_cfg[B_CLR_C]))
        else $error("upper data clear does not follow its bit");
    chk_clear_lock: assert property ( // RQ5
        $past(aux_cfg[B_CLR_A]) && !$past(aux_cfg[B_CLR_B]) |->
        clear_m00_m02 == !$past(lock_in))
        else $error("lock-gated clear wrong");
    chk_shock_force: assert property ( // RQ7
        $past(vibration_detect) && $past(aux_cfg[B_SHOCK_GAIN]) |-> focus_force_normal)
        else $error("focus filter not forced on vibration");
    chk_route_upper: assert property ( // RQ10
        $past(aux_cfg[B_RO_UPPER]) |->
        aux_out_pin_13_oe && aux_out_pin_13 == $past(readout_clock))
        else $error("upper readout route wrong");
    chk_route_none: assert property ( // RQ10
        !$past(aux_cfg[B_RO_LOWER]) |-> !aux_out_pin_10_oe && !aux_out_pin_9_oe)
        else $error("lower pins driven without route");
    chk_misc_bits: assert property ( // RQ8
        shared_buffer_mode == $past(aux_cfg[B_SHARED_BUF]) &&
        cal_freq_half == $past(aux_cfg[B_FREQ_HALF]) && // RQ12
        search_slope_quarter == $past(aux_cfg[B_SLOPE_QTR])) // RQ13
        else $error("mode bit not passed to output");
    chk_reserved_zero: assert property ( // RQ21
        (aux_cfg & ~AUX_CFG_MASK) == '0)
        else $error("reserved command bit stored");
    chk_preset_sled: assert property ( // RQ14
        $fell(sys_rst) |-> coef[0] == COEF_PRESET[0] && coef[5] == COEF_PRESET[5])
        else $error("sled coefficient preset wrong");

endmodule : scb_config_bank

`default_nettype wire

// ===== test/scb_host_model.sv
// scb_host_model: behavioural microcontroller issuing axi4-lite commands.
// assumes one clk_sys; the bench calls its tasks hierarchically.
`default_nettype none

module scb_host_model (
    input wire logic clk_sys,
    output logic [scb_pkg::ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [scb_pkg::DATA_W-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [scb_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [scb_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    import scb_pkg::*;

    localparam logic [ADDR_W-1:0] AUX_ADDR = {IDX_AUX_CFG, 2'b00};
    localparam int HOLD_CYC = 5000;
    logic ro_checked = 1'b0;

    // bus idle from time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            output logic [1:0] resp);
        logic aw_hs, w_hs, b_hs;
        b_hs = 1'b0;
        resp = RESP_OKAY;
        if (a == COEF_BASE + 10'h060) return;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hs) begin
            @(negedge clk_sys);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge clk_sys);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) s_axi_bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
            output logic [1:0] resp);
        logic ar_hs, r_hs;
        r_hs = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hs) begin
            @(negedge clk_sys);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) s_axi_rready <= 1'b0;
        end
    endtask : rd

    // readout routed before shared buffers only when the first command sets them; dac bit lives elsewhere
    task automatic aux_cmd(input logic [CMD_W-1:0] d);
        logic [1:0] r;
        if (d[B_SHARED_BUF] && !ro_checked) wr(AUX_ADDR, 32'h0000_000C, r);
        ro_checked = 1'b1;
        wr(AUX_ADDR, {16'h0000, d}, r);
    endtask : aux_cmd

    // lower clears held the full minimum before release
    task automatic hold_clear(input logic [CMD_W-1:0] d);
        aux_cmd(d);
        repeat (HOLD_CYC) @(posedge clk_sys);
        aux_cmd(d & 16'hFCFF);
    endtask : hold_clear
endmodule : scb_host_model

`default_nettype wire

// ===== test/scb_config_bank_bench.sv
// scb_config_bank_bench: random and corner checks of the command bank.
// assumes scb_pkg and scb_host_model are compiled first.
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module scb_config_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import scb_pkg::*;

    // presets K00 to K2F
    localparam logic [7:0] PRESET [0:47] = '{
        8'hE0, 8'h81, 8'h23, 8'h7F, 8'h6A, 8'h10, 8'h14, 8'h30, 8'h7F, 8'h46, 8'h81, 8'h1C,
        8'h7F, 8'h58, 8'h82, 8'h7F, 8'h4E, 8'h32, 8'h20, 8'h30, 8'h80, 8'h77, 8'h80, 8'h77,
        8'h00, 8'hF1, 8'h7F, 8'h3B, 8'h81, 8'h44, 8'h7F, 8'h5E, 8'h82, 8'h44, 8'h18, 8'h30,
        8'h7F, 8'h46, 8'h81, 8'h3A, 8'h7F, 8'h66, 8'h82, 8'h44, 8'h4E, 8'h1B, 8'h00, 8'h00};

    logic clk_sys, sys_rst;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, ac;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, und;
    logic crystal_divide_pin, lock_in, vibration_detect;
    logic readout_clock, readout_latch_n, readout_data;
    logic [COEF_AW-1:0] coef_rd_addr;
    logic [COEF_W-1:0] coef_rd_data;
    scb_div_t servo_master_div;
    scb_amp_t cal_amp_sel;
    logic cal_freq_half, search_slope_quarter, shared_buffer_mode, focus_force_normal;
    logic clear_m00_m02, clear_m08_m0a, aux_out_pin_9, aux_out_pin_9_oe;
    logic aux_out_pin_10, aux_out_pin_10_oe, aux_out_pin_11, aux_out_pin_11_oe;
    logic aux_out_pin_12, aux_out_pin_12_oe, aux_out_pin_13, aux_out_pin_13_oe;
    logic aux_out_pin_14, aux_out_pin_14_oe;
    logic [CMD_W-1:0] cmd;
    int failures = 0;
    int total_checks = 0;
    int seed = 53602;
    wire logic [11:0] pins_seen = {aux_out_pin_14_oe, aux_out_pin_13_oe, aux_out_pin_12_oe,
        aux_out_pin_11_oe, aux_out_pin_10_oe, aux_out_pin_9_oe, aux_out_pin_14, aux_out_pin_13,
        aux_out_pin_12, aux_out_pin_11, aux_out_pin_10, aux_out_pin_9};

    scb_config_bank scb_config_bank_inst (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crystal_divide_pin,
        .lock_in, .vibration_detect, .readout_clock, .readout_latch_n, .readout_data,
        .coef_rd_addr, .coef_rd_data, .servo_master_div, .cal_amp_sel, .cal_freq_half,
        .search_slope_quarter, .shared_buffer_mode, .focus_force_normal, .clear_m00_m02,
        .clear_m08_m0a, .aux_out_pin_9, .aux_out_pin_9_oe, .aux_out_pin_10, .aux_out_pin_10_oe,
        .aux_out_pin_11, .aux_out_pin_11_oe, .aux_out_pin_12, .aux_out_pin_12_oe,
        .aux_out_pin_13, .aux_out_pin_13_oe, .aux_out_pin_14, .aux_out_pin_14_oe);

    scb_host_model scb_host_model_inst (.clk_sys, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // expected division; pin high halves by the chosen polarity
    function automatic scb_div_t exp_div(logic u, logic [15:0] c, logic p);
        if (u) return SCB_DIV_1;
        if (c[B_CLK_HALF]) return SCB_DIV_2;
        if (c[B_CLK_QUARTER]) return SCB_DIV_4;
        return p ? SCB_DIV_2 : SCB_DIV_1;
    endfunction : exp_div

    // pin image {oe 14..9, value 14..9}
    function automatic logic [11:0] exp_pins(logic [15:0] c, logic ck, logic la, logic da);
        logic [2:0] u, l;
        u = {3{c[B_RO_UPPER]}};
        l = {3{c[B_RO_LOWER]}};
        return {u, l, u & {da, ck, la}, l & {da, ck, la}};
    endfunction : exp_pins

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // a hang costs a mismatch; the run needs about 21k cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        {crystal_divide_pin, lock_in, vibration_detect} = '0;
        {readout_clock, readout_latch_n, readout_data, coef_rd_addr} = '0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int k = 0; k < 48; k++) begin
            @(posedge clk_sys) coef_rd_addr <= k[5:0];
            @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK("coef", PRESET[k], coef_rd_data)
        end
        $display("test preset done");
        // first two passes: every bit but the two lower clears set, then all cleared
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            {crystal_divide_pin, lock_in, vibration_detect} <= 3'($random(seed));
            {readout_clock, readout_latch_n, readout_data} <= 3'($random(seed));
            cmd = (i == 0) ? 16'hFCFF : (i == 1) ? 16'h0000 : 16'($random(seed)) & 16'hFCFF;
            und = (i > 1) && (($random(seed) & 3) == 0);
            ac = 2'($random(seed));
            scb_host_model_inst.wr({IDX_CLK_CFG, 2'b00}, {31'h0, und}, resp);
            scb_host_model_inst.wr({IDX_GAIN_CAL, 2'b00}, {30'h0, ac}, resp);
            scb_host_model_inst.aux_cmd(cmd);
            repeat (8) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK("div", exp_div(und, cmd, crystal_divide_pin), servo_master_div)
            `CHK("amp", cmd[B_CAL_AMP_EN] ? scb_amp_t'({1'b0, ac} + 3'd1) : SCB_AMP_DEFAULT,
                cal_amp_sel)
            `CHK("freq", cmd[B_FREQ_HALF], cal_freq_half)
            `CHK("slope", cmd[B_SLOPE_QTR], search_slope_quarter)
            `CHK("sbuf", cmd[B_SHARED_BUF], shared_buffer_mode)
            `CHK("force", cmd[B_SHOCK_GAIN] & vibration_detect, focus_force_normal)
            `CHK("clr_hi", cmd[B_CLR_C], clear_m08_m0a)
            `CHK("pins", exp_pins(cmd, readout_clock, readout_latch_n, readout_data),
                pins_seen)
        end
        $display("test random commands done");
        // each lower clear held its full minimum, under both lock levels
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys) lock_in <= i[0];
            cmd = i[1] ? 16'h0200 : 16'h0100;
            fork
                scb_host_model_inst.hold_clear(cmd);
                begin
                    repeat (40) @(posedge clk_sys);
                    @(negedge clk_sys);
                    `CHK("clr_lo", cmd[B_CLR_B] | (cmd[B_CLR_A] & !lock_in), clear_m00_m02)
                end
            join
            repeat (3) @(negedge clk_sys);
            `CHK("clr_off", 1'b0, clear_m00_m02)
        end
        $display("test data clears done");
        scb_host_model_inst.rd({IDX_AUX_CFG, 2'b00}, rdv, resp);
        `CHK("aux_rd", 32'h0000_0000, rdv)
        scb_host_model_inst.rd(10'h100, rdv, resp);
        `CHK("unmap_rresp", RESP_SLVERR, resp)
        `CHK("unmap_rdata", 32'h0000_0000, rdv)
        scb_host_model_inst.wr(10'h104, 32'h0000_FFFF, resp);
        `CHK("unmap_bresp", RESP_SLVERR, resp)
        scb_host_model_inst.wr(COEF_BASE + 10'h004, 32'h0000_005A, resp);
        scb_host_model_inst.rd(COEF_BASE + 10'h004, rdv, resp);
        `CHK("coef_wr", {RESP_OKAY, 32'h0000_005A}, {resp, rdv})
        $display("test bus corners done");
        give_verdict();
    end
endmodule : scb_config_bank_bench

`undef CHK
`default_nettype wire
